// *** logic/adcs_control.sv ***
// Converter sequencer with APB register file
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "adcs_regs.svh"

module adcs_control import adcs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power state
  input wire logic standby,
  // Analog core
  output adcs_analog_type analog_out,
  input wire logic compare_hi,
  // Interrupt request
  output logic conversion_done_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  adcs_state_type state_reg;
  adcs_state_type state_next;
  logic setup_ph;
  logic access_ph;
  logic [5:0] word_idx;
  logic aligned;
  logic hit_one;
  logic hit_two;
  logic hit_lo;
  logic hit_hi;
  logic mapped;
  logic wr_go;
  logic rd_hi;
  logic busy;
  logic halt;
  logic mode_ok;
  logic time_ok;
  logic start_go;
  logic run;
  logic done_go;
  logic slot_sample;
  logic slot_step;
  logic slot_last;
  logic sar_clear;
  logic [9:0] sar_code;
  logic [9:0] result_new;
  logic [7:0] result_upper_reg;
  logic [7:0] result_lower_status_reg;
  logic [2:0] scale;
  logic [11:0] exp_cycles;

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    setup_ph = psel && !penable;
    access_ph = psel && penable;
    word_idx = paddr[7:2];
    aligned = (paddr[1:0] == 2'b00);
    hit_one = aligned && (word_idx == `ADCS_IDX_CONTROL_ONE);
    hit_two = aligned && (word_idx == `ADCS_IDX_CONTROL_TWO);
    hit_lo = aligned && (word_idx == `ADCS_IDX_RESULT_LOWER);
    hit_hi = aligned && (word_idx == `ADCS_IDX_RESULT_UPPER);
    mapped = hit_one || hit_two || hit_lo || hit_hi;
    wr_go = access_ph && pwrite && !standby;
    rd_hi = access_ph && !pwrite && hit_hi;
  end

  // ****************************************
  // Sequencer decode
  // ****************************************
  always_comb begin
    busy = (state_reg.phase == ST_CONV);
    halt = (state_reg.adc_control_one.operating_mode_field == MODE_OFF);
    mode_ok = (state_reg.adc_control_one.operating_mode_field == MODE_SOFT) ||
              (state_reg.adc_control_one.operating_mode_field == MODE_REPEAT);
    time_ok = (state_reg.adc_control_two.conv_time_sel != `ADCS_TSEL_RSV_A) &&
              (state_reg.adc_control_two.conv_time_sel != `ADCS_TSEL_RSV_B);
    start_go = !standby && !busy && mode_ok && time_ok &&
               state_reg.adc_control_one.conversion_start_bit;
    run = busy && !halt && !standby;
    done_go = run && slot_last;
    sar_clear = start_go || done_go;
    result_new = {sar_code[9:1], compare_hi};
    result_upper_reg = state_reg.result[9:2];
    result_lower_status_reg = {state_reg.result[1:0], state_reg.conversion_done_flag,
                               busy, 4'h0};
  end

  // ****************************************
  // Slot timer and approximation register
  // ****************************************
  adcs_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(run),
    .time_sel(state_reg.adc_control_two.conv_time_sel),
    .sample(slot_sample),
    .step(slot_step),
    .last(slot_last)
  );

  adcs_sar u_sar (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(sar_clear),
    .step(slot_step),
    .compare_hi(compare_hi),
    .code(sar_code)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.irq = 1'b0;
    if (wr_go && hit_one) begin
      state_next.adc_control_one = adcs_ctrl_one_type'(pwdata[7:0]);
    end
    if (wr_go && hit_two) begin
      state_next.adc_control_two = adcs_ctrl_two_type'(pwdata[5:0]);
    end
    if (start_go) begin
      state_next.phase = ST_CONV;
      state_next.adc_control_one.conversion_start_bit = 1'b0;
      state_next.conversion_done_flag = 1'b0;
      state_next.busy_cnt = 12'h000;
    end else if (busy) begin
      if (halt) begin
        state_next.phase = ST_IDLE;
      end else if (done_go) begin
        state_next.result = result_new;
        state_next.irq = 1'b1;
        state_next.busy_cnt = 12'h000;
        if (state_reg.adc_control_one.operating_mode_field == MODE_REPEAT) begin
          state_next.phase = ST_CONV;
        end else begin
          state_next.phase = ST_IDLE;
        end
      end else begin
        state_next.busy_cnt = state_reg.busy_cnt + 12'h001;
      end
    end
    if (rd_hi) begin
      state_next.conversion_done_flag = 1'b0;
    end
    if (done_go) begin
      state_next.conversion_done_flag = 1'b1;
    end
    if (setup_ph) begin
      case (1'b1)
        hit_one: state_next.rdata = {24'h000000, state_reg.adc_control_one};
        hit_two: state_next.rdata = {26'h0000000, state_reg.adc_control_two};
        hit_lo: state_next.rdata = {24'h000000, result_lower_status_reg};
        hit_hi: state_next.rdata = {24'h000000, result_upper_reg};
        default: state_next.rdata = 32'h00000000;
      endcase
    end
    if (standby) begin
      state_next.adc_control_one = adcs_ctrl_one_type'(`ADCS_RST_CONTROL_ONE);
      state_next.adc_control_two = adcs_ctrl_two_type'(`ADCS_RST_CONTROL_TWO);
      state_next.result = `ADCS_RST_RESULT;
      state_next.conversion_done_flag = 1'b0;
      state_next.phase = ST_IDLE;
      state_next.irq = 1'b0;
      state_next.busy_cnt = 12'h000;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    prdata = state_reg.rdata;
    pready = 1'b1;
    pslverr = access_ph && !mapped;
    conversion_done_irq = state_reg.irq;
    analog_out.ladder_on = !standby &&
                           (busy || state_reg.adc_control_two.ladder_always_connected);
    analog_out.sample = slot_sample;
    analog_out.input_off = state_reg.adc_control_one.analog_input_disable;
    analog_out.channel = state_reg.adc_control_one.channel_select;
    analog_out.dac_code = sar_code;
  end

  // ****************************************
  // Checks
  // ****************************************
  always_comb begin
    scale = (state_reg.adc_control_two.conv_time_sel == `ADCS_TSEL_FAST) ? 3'h0 :
            state_reg.adc_control_two.conv_time_sel - 3'h1;
    exp_cycles = 12'(`ADCS_CONV_MIN_PERIODS) << scale;
  end

  a_repeat_start_busy: assert property (@(posedge clk_sys) disable iff (reset)
    start_go && (state_reg.adc_control_one.operating_mode_field == MODE_REPEAT)
    |=> busy && !state_reg.conversion_done_flag)
    else $error("repeat start did not begin a conversion");

  a_done_store_flag: assert property (@(posedge clk_sys) disable iff (reset)
    done_go |=> state_reg.conversion_done_flag && conversion_done_irq &&
    (state_reg.result == $past(result_new)))
    else $error("completion did not store, flag and interrupt together");

  a_repeat_restart: assert property (@(posedge clk_sys) disable iff (reset)
    done_go && (state_reg.adc_control_one.operating_mode_field == MODE_REPEAT)
    |=> busy && (state_reg.busy_cnt == 12'h000))
    else $error("repeat mode did not chain the next conversion");

  a_halt_no_store: assert property (@(posedge clk_sys) disable iff (reset)
    busy && halt && !standby |=> !busy && $stable(state_reg.result) && !conversion_done_irq)
    else $error("halt stored a value or kept converting");

  a_soft_single: assert property (@(posedge clk_sys) disable iff (reset)
    done_go && (state_reg.adc_control_one.operating_mode_field == MODE_SOFT)
    && !start_go |=> !busy ##1 (!busy || $past(start_go)))
    else $error("software mode did not stop after one conversion");

  a_read_clears_flag: assert property (@(posedge clk_sys) disable iff (reset)
    rd_hi && !done_go |=> !state_reg.conversion_done_flag)
    else $error("result read did not clear the done flag");

  a_restart_keeps_result: assert property (@(posedge clk_sys) disable iff (reset)
    start_go && state_reg.conversion_done_flag
    |=> !state_reg.conversion_done_flag && $stable(state_reg.result))
    else $error("restart lost the previous result or kept the flag");

  a_full_conv_time: assert property (@(posedge clk_sys) disable iff (reset)
    done_go |-> (state_reg.busy_cnt == exp_cycles - 12'h001))
    else $error("conversion finished before its selected time");

  a_standby_init: assert property (@(posedge clk_sys) disable iff (reset)
    standby |=> (state_reg.adc_control_one == `ADCS_RST_CONTROL_ONE) &&
    (state_reg.adc_control_two == `ADCS_RST_CONTROL_TWO) && !busy &&
    (state_reg.result == `ADCS_RST_RESULT))
    else $error("standby did not initialise the converter");

  a_no_resume: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(standby) |-> !busy ##1 !busy)
    else $error("conversion resumed by itself after standby");

  a_ladder_standby: assert property (@(posedge clk_sys) disable iff (reset)
    standby |-> !analog_out.ladder_on)
    else $error("ladder connected during standby");

  a_start_bit_clears: assert property (@(posedge clk_sys) disable iff (reset)
    start_go && !(wr_go && hit_one)
    |=> !state_reg.adc_control_one.conversion_start_bit)
    else $error("start bit did not clear after starting");

  a_irq_one_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    conversion_done_irq |=> !conversion_done_irq)
    else $error("done interrupt wider than one clock");

  a_reserved_refused: assert property (@(posedge clk_sys) disable iff (reset)
    !busy && !time_ok |=> !busy)
    else $error("conversion started with a reserved time code");

  a_start_sets_busy: assert property (@(posedge clk_sys) disable iff (reset)
    start_go |=> busy && result_lower_status_reg[4])
    else $error("busy flag not raised at conversion start");

  a_done_ends_busy: assert property (@(posedge clk_sys) disable iff (reset)
    done_go && (state_reg.adc_control_one.operating_mode_field != MODE_REPEAT) |=> !busy)
    else $error("busy flag still set after a single conversion");

  a_mode_gates_start: assert property (@(posedge clk_sys) disable iff (reset)
    !busy && !mode_ok |=> !busy)
    else $error("conversion started in disabled or reserved mode");

  a_repeat_holds_busy: assert property (@(posedge clk_sys) disable iff (reset)
    busy && (state_reg.adc_control_one.operating_mode_field == MODE_REPEAT) && !standby
    |=> busy)
    else $error("repeat mode left the busy state");

  a_irq_needs_done: assert property (@(posedge clk_sys) disable iff (reset)
    conversion_done_irq |-> $past(done_go))
    else $error("done interrupt without a finished conversion");

  a_standby_no_irq: assert property (@(posedge clk_sys) disable iff (reset)
    standby |=> !conversion_done_irq && !state_reg.conversion_done_flag)
    else $error("standby left a done flag or interrupt");

  a_result_only_done: assert property (@(posedge clk_sys) disable iff (reset)
    !done_go && !standby |=> $stable(state_reg.result))
    else $error("result changed without a finished conversion");

  a_start_clears_flag: assert property (@(posedge clk_sys) disable iff (reset)
    start_go |=> !state_reg.conversion_done_flag)
    else $error("new start did not clear the done flag");

  a_start_code_reset: assert property (@(posedge clk_sys) disable iff (reset)
    start_go |=> analog_out.dac_code == `ADCS_SAR_START)
    else $error("trial code not reset at conversion start");

  a_upper_read_data: assert property (@(posedge clk_sys) disable iff (reset)
    setup_ph && hit_hi |=> prdata == {24'h000000, $past(state_reg.result[9:2])})
    else $error("upper result read returned wrong bits");

  a_lower_read_data: assert property (@(posedge clk_sys) disable iff (reset)
    setup_ph && hit_lo |=> prdata[31:6] == {24'h000000, $past(state_reg.result[1:0])})
    else $error("lower result read returned wrong bits");

endmodule : adcs_control

// *** logic/adcs_regs.svh ***
// Register indices, field positions, reset values and timing counts of the converter
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// Register indices, byte address is four times the index
`define ADCS_IDX_CONTROL_ONE 6'h0e
`define ADCS_IDX_CONTROL_TWO 6'h0f
`define ADCS_IDX_RESULT_LOWER 6'h26
`define ADCS_IDX_RESULT_UPPER 6'h27

// Field positions
`define ADCS_C1_START 7
`define ADCS_C1_INOFF 4
`define ADCS_C2_LADDER 5

// Reset values
`define ADCS_RST_CONTROL_ONE 8'h00
`define ADCS_RST_CONTROL_TWO 6'h00
`define ADCS_RST_RESULT 10'h000

// Timing, conversion time in clock periods
`define ADCS_CONV_MIN_PERIODS 39
`define ADCS_SLOTS 13
`define ADCS_FIRST_TRIAL 4'h3
`define ADCS_LAST_SLOT 4'hc
`define ADCS_TSEL_FAST 3'b000
`define ADCS_TSEL_RSV_A 3'b001
`define ADCS_TSEL_RSV_B 3'b111

// Successive approximation
`define ADCS_SAR_START 10'h200
`define ADCS_SAR_TOP 4'h9

`endif

// *** logic/adcs_pkg.sv ***
// Types shared by the converter control modules
package adcs_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_REPEAT = 2'b11
  } adcs_mode_type;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcs_phase_type;

  typedef struct packed {
    logic conversion_start_bit;
    adcs_mode_type operating_mode_field;
    logic analog_input_disable;
    logic [3:0] channel_select;
  } adcs_ctrl_one_type;

  typedef struct packed {
    logic ladder_always_connected;
    logic fixed_one;
    logic [2:0] conv_time_sel;
    logic fixed_zero;
  } adcs_ctrl_two_type;

  typedef struct packed {
    logic ladder_on;
    logic sample;
    logic input_off;
    logic [3:0] channel;
    logic [9:0] dac_code;
  } adcs_analog_type;

  typedef struct packed {
    logic [7:0] cyc;
    logic [3:0] slot;
  } adcs_timer_state_type;

  typedef struct packed {
    logic [9:0] code;
    logic [3:0] idx;
  } adcs_sar_state_type;

  typedef struct packed {
    adcs_ctrl_one_type adc_control_one;
    adcs_ctrl_two_type adc_control_two;
    logic [9:0] result;
    logic conversion_done_flag;
    adcs_phase_type phase;
    logic irq;
    logic [31:0] rdata;
    logic [11:0] busy_cnt;
  } adcs_state_type;

endpackage : adcs_pkg

// *** logic/adcs_timer.sv ***
// Conversion time slot counter
`timescale 1ns/100ps
`include "adcs_regs.svh"

module adcs_timer import adcs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [2:0] time_sel,
  // Slot events
  output logic sample,
  output logic step,
  output logic last
);

  localparam logic [7:0] SLOT_BASE = 8'(`ADCS_CONV_MIN_PERIODS / `ADCS_SLOTS);

  adcs_timer_state_type state_reg;
  adcs_timer_state_type state_next;
  logic [2:0] scale;
  logic [7:0] slot_len;
  logic slot_end;

  always_comb begin
    scale = (time_sel == `ADCS_TSEL_FAST) ? 3'h0 : time_sel - 3'h1;
    slot_len = SLOT_BASE << scale;
    slot_end = run && (state_reg.cyc == slot_len - 8'h01);
    sample = run && (state_reg.slot < `ADCS_FIRST_TRIAL);
    step = slot_end && (state_reg.slot >= `ADCS_FIRST_TRIAL);
    last = slot_end && (state_reg.slot == `ADCS_LAST_SLOT);
    state_next = state_reg;
    if (!run) begin
      state_next = '0;
    end else if (slot_end) begin
      state_next.cyc = 8'h00;
      state_next.slot = last ? 4'h0 : state_reg.slot + 4'h1;
    end else begin
      state_next.cyc = state_reg.cyc + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : adcs_timer

// *** logic/adcs_sar.sv ***
// Successive approximation code register
`timescale 1ns/100ps
`include "adcs_regs.svh"

module adcs_sar import adcs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic compare_hi,
  // Trial code
  output logic [9:0] code
);

  adcs_sar_state_type state_reg;
  adcs_sar_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.code = `ADCS_SAR_START;
      state_next.idx = `ADCS_SAR_TOP;
    end else if (step) begin
      state_next.code[state_reg.idx] = compare_hi;
      if (state_reg.idx != 4'h0) begin
        state_next.code[state_reg.idx - 4'h1] = 1'b1;
        state_next.idx = state_reg.idx - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign code = state_reg.code;

endmodule : adcs_sar

// *** sim/adcs_analog_model.sv ***
// Behavioural analog core: channel levels and comparator
`timescale 1ns/100ps

module adcs_analog_model import adcs_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Converter side
  input wire adcs_analog_type analog_out,
  input wire logic [9:0] levels [16],
  output logic compare_hi
);
  logic toggle_reg = 1'b0;
  logic [9:0] level;

  // Noise source for a disconnected comparator
  always @(posedge clk_sys) toggle_reg <= ~toggle_reg;

  // Selected pin level, no port traffic disturbs it
  assign level = levels[analog_out.channel];
  assign compare_hi = (analog_out.ladder_on && !analog_out.input_off) ?
    (level >= analog_out.dac_code) : toggle_reg;
endmodule : adcs_analog_model

// *** sim/adcs_control_bench.sv ***
// Self-checking bench of the converter sequencer
`timescale 1ns/100ps
`include "adcs_regs.svh"

module adcs_control_bench import adcs_pkg::*;;
  // ****************
  // Signals
  // ****************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby = 1'b0;
  adcs_analog_type ana;
  logic compare_hi;
  logic irq;
  logic [9:0] levels [16];
  logic [15:0] lfsr = 16'h8788;
  logic [9:0] lv;
  logic [9:0] lv2;
  logic [15:0] rv;
  logic [3:0] ch;
  logic [2:0] ts;
  logic [31:0] d;
  logic e;
  logic irq_prev = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  int run_len = 0;
  int last_len = 0;
  int irq_cnt = 0;
  int exp_irq = 0;
  int cyc = 0;

  adcs_control i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby(standby), .analog_out(ana), .compare_hi(compare_hi),
    .conversion_done_irq(irq));
  adcs_analog_model i_ana (.clk_sys(clk_sys), .analog_out(ana), .levels(levels),
    .compare_hi(compare_hi));

  always #10 clk_sys = ~clk_sys;

  // ****************
  // Helpers
  // ****************
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  function automatic int conv_len(input logic [2:0] tsel);
    return (tsel == 3'b000) ? `ADCS_CONV_MIN_PERIODS : `ADCS_CONV_MIN_PERIODS << (tsel - 1);
  endfunction : conv_len

  function automatic logic [31:0] low_word(input logic [9:0] r, input logic dn, input logic bs);
    return {24'h0, r[1:0], dn, bs, 4'h0};
  endfunction : low_word

  function automatic logic [31:0] c1(input logic st, input logic [1:0] md, input logic [3:0] c);
    return {24'h0, st, md, 1'b0, c};
  endfunction : c1

  function automatic logic [31:0] c2(input logic lad, input logic [2:0] t);
    return {26'h0, lad, 1'b1, t, 1'b0};
  endfunction : c2

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task give_verdict();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd,
    output logic [31:0] rdat, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    logic er;
    apb(1'b1, idx, wd, x, er);
    chk("write error", 32'h0, {31'h0, er});
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] x;
    logic er;
    apb(1'b0, idx, 32'h0, x, er);
    chk(nm, exp, x);
    chk("read error", 32'h0, {31'h0, er});
  endtask : rd

  task automatic wait_irq();
    int n = 0;
    exp_irq++;
    while (irq_cnt < exp_irq && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    chk("done count", exp_irq, irq_cnt);
  endtask : wait_irq

  task automatic quiet(input int n, input string nm);
    int c0 = irq_cnt;
    int hi = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (ana.ladder_on !== 1'b0) hi++;
    end
    chk(nm, c0, irq_cnt);
    chk(nm, 0, hi);
  endtask : quiet

  // Busy run length and done pulse monitor
  always @(posedge clk_sys) begin
    cyc++;
    if (irq === 1'b1) begin
      last_len = run_len;
      run_len = (ana.ladder_on === 1'b1) ? 1 : 0;
      irq_cnt++;
      if (irq_prev === 1'b1) chk("done pulse width", 32'h1, 32'h2);
    end else begin
      run_len = (ana.ladder_on === 1'b1) ? run_len + 1 : 0;
    end
    irq_prev = irq;
    if (cyc == 20000) begin
      num_errors++;
      $display("[FAIL] run time expected below 20000 seen %0d", cyc);
      give_verdict();
    end
  end

  // ****************
  // Sequence
  // ****************
  initial begin
    for (int i = 0; i < 16; i++) levels[i] = 10'h000;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    rd(`ADCS_IDX_CONTROL_ONE, 32'h0, "control one reset");
    rd(`ADCS_IDX_CONTROL_TWO, 32'h0, "control two reset");
    rd(`ADCS_IDX_RESULT_LOWER, 32'h0, "result lower reset");
    rd(`ADCS_IDX_RESULT_UPPER, 32'h0, "result upper reset");
    apb(1'b0, 6'h10, 32'h0, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    lv2 = 10'h000;
    for (int k = 0; k < 6; k++) begin
      ts = (k == 0) ? 3'b000 : 3'(k + 1);
      rv = rnd();
      ch = rv[3:0];
      rv = rnd();
      lv = rv[9:0];
      levels[ch] <= lv;
      wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_SOFT, ch));
      wr(`ADCS_IDX_CONTROL_TWO, c2(1'b0, ts));
      wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
      rd(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_SOFT, ch), "start bit");
      rd(`ADCS_IDX_RESULT_LOWER, low_word(lv2, 1'b0, 1'b1), "busy flag");
      chk("channel out", {28'h0, ch}, {28'h0, ana.channel});
      wait_irq();
      chk("conversion length", conv_len(ts), last_len);
      rd(`ADCS_IDX_RESULT_LOWER, low_word(lv, 1'b1, 1'b0), "result lower");
      rd(`ADCS_IDX_RESULT_UPPER, {24'h0, lv[9:2]}, "result upper");
      rd(`ADCS_IDX_RESULT_LOWER, low_word(lv, 1'b0, 1'b0), "done cleared");
      lv2 = lv;
    end
    // Restart before reading keeps the old result
    levels[ch] <= ~lv;
    wr(`ADCS_IDX_CONTROL_TWO, c2(1'b0, 3'b000));
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    wait_irq();
    levels[ch] <= lv;
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    rd(`ADCS_IDX_RESULT_LOWER, low_word(~lv, 1'b0, 1'b1), "restart done");
    wait_irq();
    rd(`ADCS_IDX_RESULT_UPPER, {24'h0, lv[9:2]}, "restart result");
    // Repeat mode then halt
    rv = rnd();
    lv = rv[9:0];
    levels[ch] <= lv;
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_REPEAT, ch));
    for (int k = 0; k < 3; k++) begin
      wait_irq();
      chk("repeat length", `ADCS_CONV_MIN_PERIODS, last_len);
    end
    rd(`ADCS_IDX_RESULT_UPPER, {24'h0, lv[9:2]}, "repeat result");
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_OFF, ch));
    levels[ch] <= ~lv;
    repeat (2) @(posedge clk_sys);
    quiet(100, "halted");
    rd(`ADCS_IDX_RESULT_UPPER, {24'h0, lv[9:2]}, "halt keeps result");
    // Disabled and reserved codes never start
    for (int k = 0; k < 2; k++) begin
      wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, (k == 0) ? MODE_OFF : MODE_RSVD, ch));
      quiet(100, "no start mode");
    end
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_OFF, ch));
    wr(`ADCS_IDX_CONTROL_TWO, c2(1'b0, `ADCS_TSEL_RSV_B));
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    quiet(100, "reserved time");
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_OFF, ch));
    // Standby aborts a long conversion
    wr(`ADCS_IDX_CONTROL_TWO, c2(1'b1, 3'b110));
    rd(`ADCS_IDX_CONTROL_TWO, c2(1'b1, 3'b110), "control two");
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    repeat (50) @(posedge clk_sys);
    standby <= 1'b1;
    @(negedge clk_sys);
    chk("ladder in standby", 32'h0, {31'h0, ana.ladder_on});
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    @(posedge clk_sys);
    standby <= 1'b0;
    quiet(1400, "no resume");
    rd(`ADCS_IDX_CONTROL_ONE, 32'h0, "control one cleared");
    rd(`ADCS_IDX_CONTROL_TWO, 32'h0, "control two cleared");
    rd(`ADCS_IDX_RESULT_LOWER, 32'h0, "flags cleared");
    rd(`ADCS_IDX_RESULT_UPPER, 32'h0, "result cleared");
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_OFF, ch) | 32'h10);
    @(negedge clk_sys);
    chk("input off", 32'h1, {31'h0, ana.input_off});
    // Reprogram after standby
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b0, MODE_SOFT, ch));
    wr(`ADCS_IDX_CONTROL_TWO, c2(1'b0, 3'b000));
    wr(`ADCS_IDX_CONTROL_ONE, c1(1'b1, MODE_SOFT, ch));
    wait_irq();
    rd(`ADCS_IDX_RESULT_UPPER, {24'h0, ~lv[9:2]}, "after standby");
    give_verdict();
  end
endmodule : adcs_control_bench
